// ===== pkg/pirq_regs.vh
// Purpose: Register map, field positions and reset values of the peripheral interrupt block
// Assumes: Byte-wide registers on an 8-bit register port
// Notes:   Definitions only
`ifndef PIRQ_REGS_VH
`define PIRQ_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PIRQ_ADDR_INT_CONTROL     8'h0b
`define PIRQ_ADDR_FLAGS_ONE       8'h0c
`define PIRQ_ADDR_FLAGS_TWO       8'h0d
`define PIRQ_ADDR_ENABLES_ONE     8'h8c
`define PIRQ_ADDR_ENABLES_TWO     8'h8d
`define PIRQ_ADDR_RESET_CAUSE     8'h8e
`define PIRQ_ADDR_SERIAL_TX_DATA  8'h19
`define PIRQ_ADDR_SERIAL_RX_DATA  8'h1a
`define PIRQ_ADDR_USB_CAUSE_STAT  8'h90
`define PIRQ_ADDR_USB_CAUSE_EN    8'h91

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PIRQ_BIT_PARALLEL_PORT    7
`define PIRQ_BIT_CONVERTER_DONE   6
`define PIRQ_BIT_SERIAL_RECEIVE   5
`define PIRQ_BIT_SERIAL_TRANSMIT  4
`define PIRQ_BIT_USB_SUMMARY      3
`define PIRQ_BIT_FIRST_CAPCOMP    2
`define PIRQ_BIT_TIMER_TWO        1
`define PIRQ_BIT_TIMER_ONE        0
`define PIRQ_BIT_SECOND_CAPCOMP   0
`define PIRQ_BIT_GLOBAL_ENABLE    7
`define PIRQ_BIT_PERIPH_ENABLE    6
`define PIRQ_BIT_BROWNOUT_STATUS  0
`define PIRQ_BIT_POWER_ON_STATUS  1
`define PIRQ_BIT_WATCHDOG_CAUSE   2
`define PIRQ_BIT_MASTER_CLR_CAUSE 3

// ----------------------------------------------------------------
// Masks and reset values
// ----------------------------------------------------------------
`define PIRQ_FLAGS_ONE_SW_CLR     8'hcf
`define PIRQ_FLAGS_TWO_IMPL       8'h01
`define PIRQ_RESET_CAUSE_SW_SET   8'h03
`define PIRQ_RESET_FLAGS          8'h00
`define PIRQ_RESET_ENABLES        8'h00
`define PIRQ_READ_UNMAPPED        8'h00

// ----------------------------------------------------------------
// First capture/compare mode encoding
// ----------------------------------------------------------------
`define PIRQ_CCP_MODE_OFF         2'h0
`define PIRQ_CCP_MODE_CAPTURE     2'h1
`define PIRQ_CCP_MODE_COMPARE     2'h2
`define PIRQ_CCP_MODE_PWM         2'h3

`endif

// ===== logic/pirq_sync.v
// Purpose: Two-flop synchroniser for pin-level inputs
// Assumes: Inputs are levels from outside the clk domain
// Notes:   Only the second stage may be read by other logic
`timescale 1ns/1ps

module pirq_sync #(
    parameter WIDTH = 1
) (
    input  wire             clk,    // Core clock
    input  wire             rst,    // Asynchronous clear, active high
    input  wire [WIDTH-1:0] d,      // Unsynchronised level
    output reg  [WIDTH-1:0] q       // Synchronised level
);

    reg [WIDTH-1:0] meta;

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta <= {WIDTH{1'b0}};
            q    <= {WIDTH{1'b0}};
        end
        else
        begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule

// ===== logic/pirq_usb_cause.v
// Purpose: USB cause status and cause enable registers with summary event
// Assumes: Cause events are one-cycle pulses on the core clock
// Notes:   Status bits are sticky, cleared by writing one
`timescale 1ns/1ps
`include "pirq_regs.vh"

module pirq_usb_cause (
    input  wire       clk,          // Core clock
    input  wire       sys_rst,      // Asynchronous reset, active high
    input  wire [7:0] cause_evt,    // USB cause event pulses
    input  wire       wr_status,    // Write strobe for the cause status register
    input  wire       wr_enable,    // Write strobe for the cause enable register
    input  wire [7:0] wdata,        // Write data
    output reg  [7:0] cause_status, // Sticky cause status
    output reg  [7:0] cause_enable, // Individual cause enables
    output wire       summary_set   // An enabled cause occurred this cycle
);

    wire [7:0] clr;

    assign clr         = wr_status ? wdata : 8'h00;
    // Disabled causes never raise the summary flag
    assign summary_set = |(cause_evt & cause_enable);

    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cause_status <= `PIRQ_RESET_FLAGS;
            cause_enable <= `PIRQ_RESET_ENABLES;
        end
        else
        begin
            // Specific cause stays readable here
            cause_status <= (cause_status & ~clr) | cause_evt;
            if (wr_enable)
                cause_enable <= wdata;
        end
    end

endmodule

// ===== logic/pirq_top.v
// Purpose: Peripheral interrupt flags, enables and reset-cause register
// Assumes: Peripheral events are one-cycle pulses on clk; parallel port and reset causes are pins
// Notes:   Registers read one cycle after the read strobe
//
// Behaviour
// - Parallel port access sets bit 7
// - Conversion done sets bit 6
// - Receive flag set while full, read clears
// - Transmit flag set while empty, write clears
// - USB event sets bit 3, cause readable
// - Disabled USB causes never raise summary
// - Flags set regardless of any enable but the USB cause enables
// - Second enable register gates second capcomp
// - Second flag register holds second capcomp
// - Reset cause register separates four resets
// - Brown-out bit cleared by brown-out reset
// - Peripheral enable gates all peripheral interrupts
// - First enables gate first flags bitwise
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`include "pirq_regs.vh"

module pirq_top (
    input  wire       clk,             // Core clock, 100 MHz
    input  wire       sys_rst,         // Asynchronous reset, active high
    input  wire [7:0] reg_addr,        // Register address
    input  wire [7:0] reg_wdata,       // Register write data
    input  wire       reg_wr,          // Write strobe
    input  wire       reg_rd,          // Read strobe
    output reg  [7:0] reg_rdata,       // Read data, cycle after strobe
    input  wire       parallel_access, // Parallel port access pin, high during access
    input  wire       adc_done,        // Conversion finished pulse
    input  wire       rx_load,         // Received byte loaded pulse
    input  wire [7:0] rx_byte,         // Received byte
    input  wire       tx_taken,        // Transmit buffer emptied pulse
    output reg  [7:0] tx_byte,         // Byte written for transmission
    output reg        tx_load,         // Transmit byte written pulse
    input  wire [7:0] usb_cause_evt,   // USB cause event pulses
    input  wire [1:0] ccp1_mode,       // First capcomp mode
    input  wire       ccp1_capture,    // First capcomp capture pulse
    input  wire       ccp1_match,      // First capcomp compare match pulse
    input  wire       tmr2_match,      // Timer two period match pulse
    input  wire       tmr1_overflow,   // Timer one overflow pulse
    input  wire       second_capcomp_unit_event,      // Second capcomp event pulse
    input  wire       rst_cause_por,   // Reset cause pin: power-on
    input  wire       rst_cause_bor,   // Reset cause pin: brown-out
    input  wire       rst_cause_wdt,   // Reset cause pin: watchdog
    input  wire       rst_cause_external_master_clear,  // Reset cause pin: external master clear
    output reg        irq              // Interrupt to the core, level
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    reg  [7:0] int_control;
    reg  [7:0] peripheral_flags_one;
    reg  [7:0] peripheral_flags_two;
    reg  [7:0] peripheral_enables_one;
    reg  [7:0] peripheral_enables_two;
    reg  [7:0] power_control_reset_cause;
    reg  [7:0] serial_received_data_register;
    reg        parallel_seen;
    reg  [7:0] next_flags_one;
    reg  [7:0] next_flags_two;
    reg  [7:0] next_rdata;
    wire       parallel_sync;
    wire [3:0] cause_sync;
    wire [7:0] usb_cause_status;
    wire [7:0] usb_cause_enable;
    wire       usb_summary_set;
    wire       wr_flags_one;
    wire       wr_flags_two;
    wire       wr_int_control;
    wire       wr_enables_one;
    wire       wr_enables_two;
    wire       wr_reset_cause;
    wire       wr_usb_status;
    wire       wr_usb_enable;
    wire       rd_rx_data;
    wire       wr_tx_data;
    wire       parallel_rise;
    wire       first_capcomp_hit;
    wire [7:0] set_one;
    wire [7:0] clr_one;
    wire [7:0] set_two;
    wire [7:0] clr_two;
    wire       periph_pending;

    // ----------------------------------------------------------------
    // Sticky flag update, set wins over clear
    // ----------------------------------------------------------------
    function [7:0] flag_update;
        input [7:0] cur;
        input [7:0] set;
        input [7:0] clr;
        begin
            flag_update = (cur & ~clr) | set;
        end
    endfunction

    // Strobe qualified by one register address
    function addr_hit;
        input       strobe;
        input [7:0] addr;
        input [7:0] target;
        begin
            addr_hit = strobe && (addr == target);
        end
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    pirq_sync #(
        .WIDTH (1)
    ) u_sync_parallel (
        .clk (clk),
        .rst (sys_rst),
        .d   (parallel_access),
        .q   (parallel_sync)
    );

    // Cause pins are sampled while the core is held in reset
    pirq_sync #(
        .WIDTH (4)
    ) u_sync_cause (
        .clk (clk),
        .rst (1'b0),
        .d   ({rst_cause_external_master_clear, rst_cause_wdt, rst_cause_bor, rst_cause_por}),
        .q   (cause_sync)
    );

    // ----------------------------------------------------------------
    // USB cause registers
    // ----------------------------------------------------------------
    pirq_usb_cause u_usb_cause (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .cause_evt    (usb_cause_evt),
        .wr_status    (wr_usb_status),
        .wr_enable    (wr_usb_enable),
        .wdata        (reg_wdata),
        .cause_status (usb_cause_status),
        .cause_enable (usb_cause_enable),
        .summary_set  (usb_summary_set)
    );

    // ----------------------------------------------------------------
    // Event decode
    // ----------------------------------------------------------------
    assign wr_flags_one   = addr_hit(reg_wr, reg_addr, `PIRQ_ADDR_FLAGS_ONE);
    assign wr_flags_two   = addr_hit(reg_wr, reg_addr, `PIRQ_ADDR_FLAGS_TWO);
    assign wr_int_control = addr_hit(reg_wr, reg_addr, `PIRQ_ADDR_INT_CONTROL);
    assign wr_enables_one = addr_hit(reg_wr, reg_addr, `PIRQ_ADDR_ENABLES_ONE);
    assign wr_enables_two = addr_hit(reg_wr, reg_addr, `PIRQ_ADDR_ENABLES_TWO);
    assign wr_reset_cause = addr_hit(reg_wr, reg_addr, `PIRQ_ADDR_RESET_CAUSE);
    assign wr_usb_status  = addr_hit(reg_wr, reg_addr, `PIRQ_ADDR_USB_CAUSE_STAT);
    assign wr_usb_enable  = addr_hit(reg_wr, reg_addr, `PIRQ_ADDR_USB_CAUSE_EN);
    assign rd_rx_data     = addr_hit(reg_rd, reg_addr, `PIRQ_ADDR_SERIAL_RX_DATA);
    assign wr_tx_data     = addr_hit(reg_wr, reg_addr, `PIRQ_ADDR_SERIAL_TX_DATA);
    assign parallel_rise  = parallel_sync && !parallel_seen;

    // Unused in PWM mode and while off
    assign first_capcomp_hit = (ccp1_mode == `PIRQ_CCP_MODE_CAPTURE && ccp1_capture) ||
                               (ccp1_mode == `PIRQ_CCP_MODE_COMPARE && ccp1_match);

    // Events set flags with no regard to any enable but the USB cause enables
    assign set_one = {parallel_rise,
                      adc_done,
                      rx_load,
                      tx_taken,
                      usb_summary_set,
                      first_capcomp_hit,
                      tmr2_match,
                      tmr1_overflow};

    // Software clear, or data register access for the serial flags
    assign clr_one = (wr_flags_one ? (reg_wdata & `PIRQ_FLAGS_ONE_SW_CLR) : 8'h00) |
                     {2'b00, rd_rx_data, wr_tx_data, 4'h0};

    assign set_two = {7'h00, second_capcomp_unit_event};
    assign clr_two = wr_flags_two ? (reg_wdata & `PIRQ_FLAGS_TWO_IMPL) : 8'h00;

    always @*
    begin
        next_flags_one = flag_update(peripheral_flags_one, set_one, clr_one);
        next_flags_two = flag_update(peripheral_flags_two, set_two, clr_two);
    end

    // ----------------------------------------------------------------
    // Interrupt gating
    // ----------------------------------------------------------------
    assign periph_pending = |(peripheral_flags_one & peripheral_enables_one) ||
                            |(peripheral_flags_two & peripheral_enables_two);

    // ----------------------------------------------------------------
    // Flag, enable and data registers
    // ----------------------------------------------------------------
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            int_control                   <= `PIRQ_RESET_ENABLES;
            peripheral_flags_one          <= `PIRQ_RESET_FLAGS;
            peripheral_flags_two          <= `PIRQ_RESET_FLAGS;
            peripheral_enables_one        <= `PIRQ_RESET_ENABLES;
            peripheral_enables_two        <= `PIRQ_RESET_ENABLES;
            serial_received_data_register <= 8'h00;
            parallel_seen                 <= 1'b0;
            tx_byte                       <= 8'h00;
            tx_load                       <= 1'b0;
            irq                           <= 1'b0;
        end
        else
        begin
            peripheral_flags_one <= next_flags_one;
            peripheral_flags_two <= next_flags_two;
            parallel_seen        <= parallel_sync;
            if (wr_int_control)
                int_control <= reg_wdata;
            if (wr_enables_one)
                peripheral_enables_one <= reg_wdata;
            if (wr_enables_two)
                peripheral_enables_two <= reg_wdata & `PIRQ_FLAGS_TWO_IMPL;
            if (rx_load)
                serial_received_data_register <= rx_byte;
            tx_load <= wr_tx_data;
            if (wr_tx_data)
                tx_byte <= reg_wdata;
            irq <= int_control[`PIRQ_BIT_GLOBAL_ENABLE] &&
                   int_control[`PIRQ_BIT_PERIPH_ENABLE] && periph_pending;
        end
    end

    // ----------------------------------------------------------------
    // Reset cause register
    // ----------------------------------------------------------------
    // Kept out of the async reset so that a cause survives the reset it names
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            if (cause_sync[0])
            begin
                power_control_reset_cause <= 8'h00;
            end
            else if (cause_sync[1])
            begin
                power_control_reset_cause[`PIRQ_BIT_BROWNOUT_STATUS]  <= 1'b0;
                power_control_reset_cause[`PIRQ_BIT_WATCHDOG_CAUSE]   <= 1'b0;
                power_control_reset_cause[`PIRQ_BIT_MASTER_CLR_CAUSE] <= 1'b0;
            end
            else if (cause_sync[2])
            begin
                power_control_reset_cause[`PIRQ_BIT_WATCHDOG_CAUSE]   <= 1'b1;
                power_control_reset_cause[`PIRQ_BIT_MASTER_CLR_CAUSE] <= 1'b0;
            end
            else if (cause_sync[3])
            begin
                power_control_reset_cause[`PIRQ_BIT_WATCHDOG_CAUSE]   <= 1'b0;
                power_control_reset_cause[`PIRQ_BIT_MASTER_CLR_CAUSE] <= 1'b1;
            end
        end
        else if (wr_reset_cause)
        begin
            // Software arms the power-on and brown-out status bits
            power_control_reset_cause <= (power_control_reset_cause & ~`PIRQ_RESET_CAUSE_SW_SET) |
                                         (reg_wdata & `PIRQ_RESET_CAUSE_SW_SET);
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    always @*
    begin
        case (reg_addr)
            `PIRQ_ADDR_INT_CONTROL:    next_rdata = int_control;
            `PIRQ_ADDR_FLAGS_ONE:      next_rdata = peripheral_flags_one;
            `PIRQ_ADDR_FLAGS_TWO:      next_rdata = peripheral_flags_two;
            `PIRQ_ADDR_ENABLES_ONE:    next_rdata = peripheral_enables_one;
            `PIRQ_ADDR_ENABLES_TWO:    next_rdata = peripheral_enables_two;
            `PIRQ_ADDR_RESET_CAUSE:    next_rdata = {4'h0, power_control_reset_cause[3:0]};
            `PIRQ_ADDR_SERIAL_RX_DATA: next_rdata = serial_received_data_register;
            `PIRQ_ADDR_SERIAL_TX_DATA: next_rdata = tx_byte;
            `PIRQ_ADDR_USB_CAUSE_STAT: next_rdata = usb_cause_status;
            `PIRQ_ADDR_USB_CAUSE_EN:   next_rdata = usb_cause_enable;
            default:                   next_rdata = `PIRQ_READ_UNMAPPED;
        endcase
    end

    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= next_rdata;
        else
            reg_rdata <= 8'h00;
    end

endmodule

// ===== tb/pirq_asserts.sv
// Purpose: Port-level checks of the peripheral interrupt block
// Assumes: One clock, asynchronous active-high reset
// Notes:   Enable shadows are rebuilt from bus writes
`timescale 1ns/1ps

module pirq_asserts (
    input wire       clk,           // Core clock
    input wire       sys_rst,       // Reset, active high
    input wire [7:0] reg_addr,      // Register address
    input wire [7:0] reg_wdata,     // Write data
    input wire       reg_wr,        // Write strobe
    input wire       reg_rd,        // Read strobe
    input wire [7:0] reg_rdata,     // Read data
    input wire [7:0] tx_byte,       // Transmit byte
    input wire       tx_load,       // Transmit load pulse
    input wire       adc_done,      // Conversion done pulse
    input wire       rx_load,       // Receive load pulse
    input wire       tmr1_overflow, // Timer one overflow pulse
    input wire       irq            // Interrupt to the core
);
// ----------------------------------------------------------------
// Enable shadows
// ----------------------------------------------------------------
reg glob_en;
reg per_en;
reg t1_en;
always @(posedge clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        glob_en <= 1'b0;
        per_en  <= 1'b0;
        t1_en   <= 1'b0;
    end
    else if (reg_wr && reg_addr == 8'h0b)
    begin
        glob_en <= reg_wdata[7];
        per_en  <= reg_wdata[6];
    end
    else if (reg_wr && reg_addr == 8'h8c)
        t1_en <= reg_wdata[0];
end
// ----------------------------------------------------------------
// Properties
// ----------------------------------------------------------------
default clocking cb @(posedge clk);
endclocking
default disable iff (sys_rst);
sequence s_tx_write;
    reg_wr && reg_addr == 8'h19;
endsequence
sequence s_ovf_armed;
    tmr1_overflow && glob_en && per_en && t1_en ##1 !reg_wr;
endsequence
sequence s_read_flags;
    reg_rd && reg_addr == 8'h0c;
endsequence
a_tx_load_pulse: assert property (s_tx_write |=> tx_load && tx_byte == $past(reg_wdata))
    else $error("transmit write gave no load pulse");
a_tx_load_cause: assert property (!(reg_wr && reg_addr == 8'h19) |=> !tx_load)
    else $error("load pulse without transmit write");
a_irq_needs_en: assert property (!(glob_en && per_en) |=> !irq)
    else $error("interrupt while peripheral enable off");
a_irq_tmr_walk: assert property (s_ovf_armed |=> irq)
    else $error("enabled overflow did not raise interrupt");
a_flags_two_impl: assert property (reg_rd && reg_addr == 8'h0d |=> reg_rdata[7:1] == 7'h00)
    else $error("unused flag bits read nonzero");
a_cause_upper: assert property (reg_rd && reg_addr == 8'h8e |=> reg_rdata[7:4] == 4'h0)
    else $error("reset cause upper bits nonzero");
a_conv_sets: assert property (adc_done ##1 s_read_flags |=> reg_rdata[6])
    else $error("conversion flag missing");
a_rx_sets: assert property (rx_load ##1 s_read_flags |=> reg_rdata[5])
    else $error("receive flag missing");
endmodule

bind pirq_top pirq_asserts chk_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_byte(tx_byte), .tx_load(tx_load),
    .adc_done(adc_done), .rx_load(rx_load), .tmr1_overflow(tmr1_overflow), .irq(irq));

// ===== tb/pirq_periph_model.sv
// Purpose: Peripheral units beside the interrupt block
// Assumes: fire bits 6:0 request one-cycle events, bit 7 a four-cycle parallel access level
// Notes:   Receive data is garbled outside its load pulse
`timescale 1ns/1ps

module pirq_periph_model #(
    parameter [3:0] TX_DELAY = 4'h6
) (
    input  wire       clk,             // Core clock
    input  wire       sys_rst,         // Reset, active high
    input  wire [7:0] fire,            // Event requests
    input  wire [7:0] usb_fire,        // USB cause requests
    input  wire       tx_load,         // Transmit byte written
    output reg  [5:0] evt,             // second_capcomp_unit,ccp1 match,capture,tmr2,tmr1 and conversion
    output reg        rx_load,         // Received byte loaded
    output reg  [7:0] rx_byte,         // Received byte
    output reg  [7:0] usb_cause_evt,   // USB cause pulses
    output reg        tx_taken,        // Transmit buffer emptied
    output wire       parallel_access  // Parallel port access level
);
reg [2:0] pp_cnt;
reg [3:0] tx_cnt;
assign parallel_access = pp_cnt != 3'h0;
always @(posedge clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        evt           <= 6'h00;
        rx_load       <= 1'b0;
        rx_byte       <= 8'h00;
        usb_cause_evt <= 8'h00;
        tx_taken      <= 1'b0;
        pp_cnt        <= 3'h0;
        tx_cnt        <= 4'h0;
    end
    else
    begin
        evt           <= fire[5:0];
        rx_load       <= fire[6];
        rx_byte       <= fire[6] ? 8'h3c : ~rx_byte;
        usb_cause_evt <= usb_fire;
        pp_cnt        <= fire[7] ? 3'h4 : pp_cnt - {2'h0, |pp_cnt};
        tx_cnt        <= tx_load ? TX_DELAY : tx_cnt - {3'h0, |tx_cnt};
        tx_taken      <= tx_cnt == 4'h1;
    end
end
endmodule

// ===== tb/testbench.sv
// Purpose: Self-checking bench of the peripheral interrupt block
// Assumes: Register port answers one cycle after the read strobe
// Notes:   Reset values first, then table rows, USB cause, interrupt, serial and reset cases
`timescale 1ns/1ps

module testbench;
reg clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, fire = 8'h00, usb_fire = 8'h00, d;
reg [1:0] ccp1_mode = 2'h0;
reg [3:0] cause = 4'h1;
reg [37:0] r;
wire [7:0] reg_rdata, tx_byte, rx_byte, usb_cause_evt;
wire [5:0] evt;
wire tx_load, irq, rx_load, tx_taken, parallel_access;
int mismatches = 0, checks_done = 0, cycles = 0, i;
// Row: fire, usb, mode, address, expected, wait
reg [37:0] rows [0:9] = '{{8'h01, 8'h00, 2'h0, 8'h0c, 8'h01, 4'h0}, {8'h02, 8'h00, 2'h0, 8'h0c, 8'h02, 4'h0},
    {8'h04, 8'h00, 2'h1, 8'h0c, 8'h04, 4'h0}, {8'h08, 8'h00, 2'h2, 8'h0c, 8'h04, 4'h0},
    {8'h0c, 8'h00, 2'h3, 8'h0c, 8'h00, 4'h0}, {8'h20, 8'h00, 2'h0, 8'h0c, 8'h40, 4'h0},
    {8'h80, 8'h00, 2'h0, 8'h0c, 8'h80, 4'h4}, {8'h10, 8'h00, 2'h0, 8'h0d, 8'h01, 4'h0},
    {8'h00, 8'hff, 2'h0, 8'h0c, 8'h00, 4'h0}, {8'h0c, 8'h00, 2'h0, 8'h0c, 8'h00, 4'h0}};

pirq_top dut_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .parallel_access(parallel_access), .adc_done(evt[5]),
    .rx_load(rx_load), .rx_byte(rx_byte), .tx_taken(tx_taken), .tx_byte(tx_byte), .tx_load(tx_load),
    .usb_cause_evt(usb_cause_evt), .ccp1_mode(ccp1_mode), .ccp1_capture(evt[2]), .ccp1_match(evt[3]),
    .tmr2_match(evt[1]), .tmr1_overflow(evt[0]), .second_capcomp_unit_event(evt[4]), .rst_cause_por(cause[0]),
    .rst_cause_bor(cause[1]), .rst_cause_wdt(cause[2]), .rst_cause_external_master_clear(cause[3]), .irq(irq));
pirq_periph_model model_u (.clk(clk), .sys_rst(sys_rst), .fire(fire), .usb_fire(usb_fire), .tx_load(tx_load),
    .evt(evt), .rx_load(rx_load), .rx_byte(rx_byte), .usb_cause_evt(usb_cause_evt), .tx_taken(tx_taken),
    .parallel_access(parallel_access));

initial
begin
    forever #5 clk = ~clk;
end
// ----------------------------------------------------------------
// Bus and check tasks
// ----------------------------------------------------------------
task check(input [7:0] seen, input [7:0] exp);
begin
    checks_done = checks_done + 1;
    if (seen !== exp)
    begin
        mismatches = mismatches + 1;
        $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
end
endtask
task wr(input [7:0] a, input [7:0] v);
begin
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
end
endtask
task rd(input [7:0] a, output [7:0] v);
begin
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
end
endtask
task pulse(input [7:0] f, input [7:0] u);
begin
    @(posedge clk);
    fire <= f;
    usb_fire <= u;
    @(posedge clk);
    fire <= 8'h00;
    usb_fire <= 8'h00;
end
endtask
task rst(input [3:0] c);
begin
    @(posedge clk);
    cause <= c;
    sys_rst <= 1'b1;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    cause <= 4'h0;
end
endtask
task wait_irq(input bit exp);
begin
    repeat (2) @(posedge clk);
    #1 check({7'h00, irq}, {7'h00, exp});
end
endtask
task stop_test;
begin
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
        $display("Regression OK");
    else
        $display("Regression broken");
    $finish;
end
endtask
always @(posedge clk)
begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
        mismatches = mismatches + 1;
        stop_test;
    end
end
// ----------------------------------------------------------------
// Main sequence
// ----------------------------------------------------------------
initial
begin
    rst(4'h1);
    #1 check(reg_rdata, 8'h00);
    check(tx_byte, 8'h00);
    check({6'h00, tx_load, irq}, 8'h00);
    rd(8'h0c, d);
    check(d, 8'h00);
    rd(8'h8e, d);
    check(d, 8'h00);
    rd(8'h55, d);
    check(d, 8'h00);
    for (i = 0; i < 10; i++)
    begin
        r = rows[i];
        ccp1_mode <= r[21:20];
        wr(8'h0c, 8'hff);
        pulse(r[37:30], r[29:22]);
        repeat (r[3:0]) @(posedge clk);
        rd(r[19:12], d);
        check(d, r[11:4]);
    end
    wr(8'h91, 8'h04);
    wr(8'h90, 8'hff);
    pulse(8'h00, 8'h04);
    rd(8'h0c, d);
    check(d, 8'h08);
    rd(8'h90, d);
    check(d, 8'h04);
    rd(8'h91, d);
    check(d, 8'h04);
    // Interrupt raised, gated, masked and cleared
    wr(8'h0c, 8'hff);
    wr(8'h8c, 8'h01);
    wr(8'h0b, 8'hc0);
    pulse(8'h01, 8'h00);
    wait_irq(1'b1);
    wr(8'h0b, 8'h80);
    wait_irq(1'b0);
    wr(8'h0b, 8'hc0);
    wr(8'h8c, 8'h00);
    wait_irq(1'b0);
    wr(8'h8c, 8'h01);
    wr(8'h0c, 8'h01);
    wait_irq(1'b0);
    wr(8'h8d, 8'hff);
    rd(8'h8d, d);
    check(d, 8'h01);
    wait_irq(1'b1);
    wr(8'h8d, 8'h00);
    // Serial transmit and receive
    wr(8'h19, 8'h5a);
    #1 check(tx_byte, 8'h5a);
    repeat (9) @(posedge clk);
    wr(8'h0c, 8'hff);
    rd(8'h0c, d);
    check(d & 8'h10, 8'h10);
    wr(8'h19, 8'h33);
    rd(8'h0c, d);
    check(d & 8'h10, 8'h00);
    pulse(8'h40, 8'h00);
    rd(8'h0c, d);
    check(d & 8'h20, 8'h20);
    rd(8'h1a, d);
    check(d, 8'h3c);
    rd(8'h0c, d);
    check(d & 8'h20, 8'h00);
    // Reset causes
    wr(8'h8e, 8'h03);
    rst(4'h4);
    rd(8'h8e, d);
    check(d, 8'h07);
    rst(4'h8);
    rd(8'h8e, d);
    check(d & 8'h0b, 8'h0b);
    rst(4'h2);
    rd(8'h8e, d);
    check(d & 8'h01, 8'h00);
    rst(4'h1);
    rd(8'h8e, d);
    check(d & 8'h03, 8'h00);
    stop_test;
end
endmodule
